// *** rtl/mfs_regs.svh ***
// Register offsets, field positions and reset values for the method sequencer
`ifndef MFS_REGS_SVH
`define MFS_REGS_SVH

// ==========================================================
// Register byte offsets
`define MFS_REG_CTRL 8'h00
`define MFS_REG_STATUS 8'h04
`define MFS_REG_PADDR 8'h08
`define MFS_REG_PDATA 8'h0C
`define MFS_REG_MTAB 8'h10

// ==========================================================
// Control register fields
`define MFS_CTRL_START 0
`define MFS_CTRL_ABORT 1
`define MFS_CTRL_MSEL_LO 4

// ==========================================================
// Method table write fields
`define MFS_MTAB_IDX_LO 16

// ==========================================================
// Step word fields
`define MFS_STEP_OP_LO 12
`define MFS_STEP_CNT_LO 8

// ==========================================================
// Reset values
`define MFS_STEP_RST 16'h0000
`define MFS_RD_RST 32'h0000_0000

`endif

// *** rtl/mfs_pkg.sv ***
// Types shared by the method sequencer
package mfs_pkg;

    // Sequencer states, Gray along idle-run-pump-event
    typedef enum logic [1:0] {
        MFS_IDLE = 2'b00,
        MFS_RUN  = 2'b01,
        MFS_PUMP = 2'b11,
        MFS_EVT  = 2'b10
    } mfs_state_t;

    // Step operation codes
    typedef enum logic [3:0] {
        MFS_OP_END    = 4'h0,
        MFS_OP_PUMP   = 4'h1,
        MFS_OP_REPEAT = 4'h2,
        MFS_OP_LINK   = 4'h3,
        MFS_OP_CALL   = 4'h4,
        MFS_OP_STOP   = 4'h5,
        MFS_OP_TRIG   = 4'h6,
        MFS_OP_VALVE  = 4'h7,
        MFS_OP_EVENT  = 4'h8
    } mfs_op_t;

    // Valve control modes
    typedef enum logic [1:0] {
        MFS_VLV_AUTO = 2'h0,
        MFS_VLV_ON   = 2'h1,
        MFS_VLV_OFF  = 2'h2
    } mfs_vlv_t;

    // Wake conditions of an event step
    typedef enum logic [1:0] {
        MFS_EV_FALL  = 2'h0,
        MFS_EV_RISE  = 2'h1,
        MFS_EV_PRESS = 2'h2
    } mfs_ev_t;

endpackage

// *** rtl/mfs_seq.sv ***
// Method step sequencer with trigger, valve and event handling
`timescale 1ns/1ps
`include "mfs_regs.svh"

module mfs_seq #(
    parameter int PDEPTH = 64, // Program steps
    parameter int MDEPTH = 8,  // Method table entries
    parameter int SDEPTH = 4   // Call nesting depth
) (
    input wire logic i_clk,           // 125 MHz clock
    input wire logic i_rst_n,         // Async reset, low
    input wire logic [7:0] i_addr,    // Register byte address
    input wire logic [31:0] i_wdata,  // Write data
    input wire logic i_wr,            // Write strobe
    input wire logic i_rd,            // Read strobe
    output logic [31:0] o_rdata,      // Read data, next cycle
    input wire logic i_event,         // Event pin, async
    input wire logic i_touch,         // Screen touch pulse
    input wire logic i_pump_done,     // Pump step finished
    output logic o_pump_run,          // Pump step active
    output logic o_pump_dir,          // 1 withdraw, 0 infuse
    output logic [2:0] o_trig,        // Trigger outputs
    output logic o_valve,             // Valve output
    output logic o_running            // Method executing
);
    localparam int PW = $clog2(PDEPTH);
    localparam int MW = $clog2(MDEPTH);
    localparam int SW = $clog2(SDEPTH + 1);
    localparam int KW = $clog2(SDEPTH);

    // ==========================================================
    // Storage and state
    logic [15:0] prog_r [PDEPTH];
    logic [PW-1:0] mtab_r [MDEPTH];
    logic [PW-1:0] stk_r [SDEPTH];
    logic [PW-1:0] paddr_r;
    logic [PW-1:0] pc_r;
    logic [SW-1:0] sp_r;
    logic [7:0] loop_cnt_r;
    logic loop_act_r;
    mfs_pkg::mfs_state_t state_r;
    mfs_pkg::mfs_vlv_t vmode_r;
    logic auto_lvl_r;
    logic last_dir_r;
    logic ev_s1_r, ev_s2_r, ev_d_r;

    // ==========================================================
    // Decode of the step under the pointer
    logic [15:0] step;
    mfs_pkg::mfs_op_t op;
    logic exec, wake, start_p, abort_p;
    logic [MW-1:0] start_idx;
    logic [7:0] remain;

    // Method start lookup, shared by start, link and call
    function automatic logic [PW-1:0] meth_start(input logic [MW-1:0] idx);
        return mtab_r[idx];
    endfunction

    assign step = prog_r[pc_r];
    assign op = mfs_pkg::mfs_op_t'(step[`MFS_STEP_OP_LO +: 4]);
    assign exec = (state_r == mfs_pkg::MFS_RUN);
    assign start_p = i_wr && (i_addr == `MFS_REG_CTRL) && i_wdata[`MFS_CTRL_START];
    assign abort_p = i_wr && (i_addr == `MFS_REG_CTRL) && i_wdata[`MFS_CTRL_ABORT];
    assign start_idx = i_wdata[`MFS_CTRL_MSEL_LO +: MW];
    assign remain = loop_act_r ? loop_cnt_r : step[7:0];

    // Wake selection; press mode never looks at the pin
    always_comb begin
        case (mfs_pkg::mfs_ev_t'(step[1:0]))
            mfs_pkg::MFS_EV_FALL: wake = ev_d_r && !ev_s2_r;
            mfs_pkg::MFS_EV_RISE: wake = !ev_d_r && ev_s2_r;
            mfs_pkg::MFS_EV_PRESS: wake = i_touch;
            default: wake = 1'b0;
        endcase
    end

    // ==========================================================
    // Event pin synchroniser, third stage feeds edge detect
    // Resets to the pin's idle high level, so no false edge after reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ev_s1_r <= 1'b1;
            ev_s2_r <= 1'b1;
            ev_d_r <= 1'b1;
        end else begin
            ev_s1_r <= i_event;
            ev_s2_r <= ev_s1_r;
            ev_d_r <= ev_s2_r;
        end
    end

    // ==========================================================
    // Program and method table loading; address auto-increments
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            paddr_r <= '0;
            for (int i = 0; i < PDEPTH; i++) prog_r[i] <= `MFS_STEP_RST;
            for (int i = 0; i < MDEPTH; i++) mtab_r[i] <= '0;
        end else if (i_wr) begin
            if (i_addr == `MFS_REG_PADDR) begin
                paddr_r <= i_wdata[PW-1:0];
            end else if (i_addr == `MFS_REG_PDATA) begin
                prog_r[paddr_r] <= i_wdata[15:0];
                paddr_r <= paddr_r + 1'b1;
            end else if (i_addr == `MFS_REG_MTAB) begin
                mtab_r[i_wdata[`MFS_MTAB_IDX_LO +: MW]] <= i_wdata[PW-1:0];
            end
        end
    end

    // ==========================================================
    // Step sequencer; loads while running would corrupt the method
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= mfs_pkg::MFS_IDLE;
            pc_r <= '0;
            sp_r <= '0;
            loop_act_r <= 1'b0;
            loop_cnt_r <= 8'h00;
            o_pump_run <= 1'b0;
            o_pump_dir <= 1'b0;
            for (int i = 0; i < SDEPTH; i++) stk_r[i] <= '0;
        end else if (abort_p) begin
            state_r <= mfs_pkg::MFS_IDLE;
            o_pump_run <= 1'b0;
        end else begin
            case (state_r)
                mfs_pkg::MFS_IDLE: begin
                    if (start_p) begin
                        pc_r <= meth_start(start_idx);
                        sp_r <= '0;
                        loop_act_r <= 1'b0;
                        state_r <= mfs_pkg::MFS_RUN;
                    end
                end
                mfs_pkg::MFS_RUN: begin
                    case (op)
                        mfs_pkg::MFS_OP_PUMP: begin
                            o_pump_run <= 1'b1;
                            o_pump_dir <= step[0];
                            state_r <= mfs_pkg::MFS_PUMP;
                        end
                        mfs_pkg::MFS_OP_REPEAT: begin
                            if (remain == 8'h00) begin
                                loop_act_r <= 1'b0;
                                pc_r <= pc_r + 1'b1;
                            end else begin
                                loop_act_r <= 1'b1;
                                loop_cnt_r <= remain - 8'h01;
                                pc_r <= step[PW-1:0];
                            end
                        end
                        mfs_pkg::MFS_OP_LINK: begin
                            pc_r <= meth_start(step[MW-1:0]);
                        end
                        mfs_pkg::MFS_OP_CALL: begin
                            if (sp_r == SW'(SDEPTH)) begin
                                state_r <= mfs_pkg::MFS_IDLE; // Overflow ends the run
                            end else begin
                                stk_r[sp_r[KW-1:0]] <= pc_r + 1'b1;
                                sp_r <= sp_r + 1'b1;
                                pc_r <= meth_start(step[MW-1:0]);
                            end
                        end
                        mfs_pkg::MFS_OP_STOP: begin
                            o_pump_run <= 1'b0;
                            state_r <= mfs_pkg::MFS_IDLE;
                        end
                        mfs_pkg::MFS_OP_TRIG, mfs_pkg::MFS_OP_VALVE: begin
                            pc_r <= pc_r + 1'b1;
                        end
                        mfs_pkg::MFS_OP_EVENT: begin
                            state_r <= mfs_pkg::MFS_EVT;
                        end
                        default: begin
                            // End of a method: back to caller or finish
                            if (sp_r != '0) begin
                                pc_r <= stk_r[KW'(sp_r - 1'b1)];
                                sp_r <= sp_r - 1'b1;
                            end else begin
                                state_r <= mfs_pkg::MFS_IDLE;
                            end
                        end
                    endcase
                end
                mfs_pkg::MFS_PUMP: begin
                    if (i_pump_done) begin
                        o_pump_run <= 1'b0;
                        pc_r <= pc_r + 1'b1;
                        state_r <= mfs_pkg::MFS_RUN;
                    end
                end
                mfs_pkg::MFS_EVT: begin
                    if (wake) begin
                        pc_r <= pc_r + 1'b1;
                        state_r <= mfs_pkg::MFS_RUN;
                    end
                end
                default: state_r <= mfs_pkg::MFS_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Trigger outputs change only on a trigger step
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_trig <= 3'h0;
        end else if (exec && op == mfs_pkg::MFS_OP_TRIG && step[5:4] != 2'h3) begin
            o_trig[step[5:4]] <= step[0];
        end
    end

    // ==========================================================
    // Valve mode: reverts to auto whenever not running
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vmode_r <= mfs_pkg::MFS_VLV_AUTO;
        end else if (state_r == mfs_pkg::MFS_IDLE) begin
            vmode_r <= mfs_pkg::MFS_VLV_AUTO;
        end else if (exec && op == mfs_pkg::MFS_OP_VALVE) begin
            vmode_r <= mfs_pkg::mfs_vlv_t'(step[1:0]);
        end
    end

    // Auto level flips on each change of pumping direction
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            auto_lvl_r <= 1'b0;
            last_dir_r <= 1'b0;
            o_valve <= 1'b0;
        end else begin
            if (exec && op == mfs_pkg::MFS_OP_PUMP) begin
                last_dir_r <= step[0];
                if (step[0] != last_dir_r) auto_lvl_r <= !auto_lvl_r;
            end
            case (vmode_r)
                mfs_pkg::MFS_VLV_ON: o_valve <= 1'b1;
                mfs_pkg::MFS_VLV_OFF: o_valve <= 1'b0;
                default: o_valve <= auto_lvl_r;
            endcase
        end
    end

    // ==========================================================
    // Read port; unmapped addresses read zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= `MFS_RD_RST;
            o_running <= 1'b0;
        end else begin
            o_running <= (state_r != mfs_pkg::MFS_IDLE);
            o_rdata <= `MFS_RD_RST;
            if (i_rd && i_addr == `MFS_REG_STATUS) begin
                o_rdata[0] <= (state_r != mfs_pkg::MFS_IDLE);
                o_rdata[1] <= (state_r == mfs_pkg::MFS_EVT);
                o_rdata[2] <= o_pump_run;
                o_rdata[3] <= o_pump_dir;
                o_rdata[6:4] <= o_trig;
                o_rdata[7] <= o_valve;
                o_rdata[8 +: PW] <= pc_r;
                o_rdata[17:16] <= vmode_r;
            end else if (i_rd && i_addr == `MFS_REG_PADDR) begin
                o_rdata[PW-1:0] <= paddr_r;
            end
        end
    end

    // ==========================================================
    // Checks
    sequence s_trig_step;
        exec && op == mfs_pkg::MFS_OP_TRIG && step[5:4] != 2'h3;
    endsequence

    sequence s_evt_wait;
        state_r == mfs_pkg::MFS_EVT && !wake && !abort_p;
    endsequence

    a_trig_update: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_trig_step |=> o_trig[$past(step[5:4])] == $past(step[0]))
        else $error("trigger not driven to level");

    a_trig_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(exec && op == mfs_pkg::MFS_OP_TRIG) |=> $stable(o_trig))
        else $error("trigger changed without step");

    a_link_jump: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        exec && op == mfs_pkg::MFS_OP_LINK && !abort_p
        |=> pc_r == mtab_r[$past(step[MW-1:0])] && $stable(sp_r))
        else $error("link did not jump");

    a_call_push: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        exec && op == mfs_pkg::MFS_OP_CALL && sp_r != SW'(SDEPTH) && !abort_p
        |=> sp_r == $past(sp_r) + 1'b1 && stk_r[$past(sp_r[KW-1:0])] == $past(pc_r) + 1'b1)
        else $error("call did not save return");

    a_stop_halt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        exec && op == mfs_pkg::MFS_OP_STOP
        |=> !o_pump_run && state_r == mfs_pkg::MFS_IDLE ##1 !o_running)
        else $error("stop did not halt");

    a_valve_revert: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_r == mfs_pkg::MFS_IDLE |=> vmode_r == mfs_pkg::MFS_VLV_AUTO)
        else $error("valve mode not auto");

    a_valve_force: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        vmode_r == mfs_pkg::MFS_VLV_ON |=> o_valve)
        else $error("valve not forced on");

    a_evt_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_evt_wait |=> state_r == mfs_pkg::MFS_EVT && $stable(pc_r))
        else $error("event wait left early");

    a_evt_fall: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_r == mfs_pkg::MFS_EVT && step[1:0] == 2'h0 && ev_d_r && !ev_s2_r && !abort_p
        |=> state_r == mfs_pkg::MFS_RUN && pc_r == $past(pc_r) + 1'b1)
        else $error("fall edge missed");

    a_step_adv: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        exec && op == mfs_pkg::MFS_OP_VALVE && !abort_p |=> pc_r == $past(pc_r) + 1'b1)
        else $error("step did not advance");

    a_evt_rise: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_r == mfs_pkg::MFS_EVT && step[1:0] == 2'h1 && !ev_d_r && ev_s2_r && !abort_p
        |=> state_r == mfs_pkg::MFS_RUN && pc_r == $past(pc_r) + 1'b1)
        else $error("rise edge missed");

    a_evt_press: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_r == mfs_pkg::MFS_EVT && step[1:0] == 2'h2 && !i_touch && !abort_p
        |=> state_r == mfs_pkg::MFS_EVT)
        else $error("press wait left without touch");

endmodule // mfs_seq

// *** sim/mfs_ext_model.sv ***
// External bench equipment: event pin source and pump engine
`timescale 1ns/1ps

module mfs_ext_model (
    input wire logic i_clk,      // Sequencer clock
    input wire logic i_pump_run, // Pump step active
    output logic o_event,        // Event pin level
    output logic o_pump_done     // Pump step finished
);
    bit slow = 1'b0;

    // ====
    // Pin idles high until a scenario moves it
    initial begin
        o_event = 1'b1;
        o_pump_done = 1'b0;
    end

    // Pump engine, alternately prompt and slow to finish
    always begin
        @(posedge i_clk);
        if (i_pump_run === 1'b1) begin
            repeat (slow ? 6 : 1) @(posedge i_clk);
            o_pump_done <= 1'b1;
            @(posedge i_clk);
            o_pump_done <= 1'b0;
            @(posedge i_clk);
            slow = !slow;
        end
    end

    // Pin moves off the clock edge, as real equipment would
    task automatic set_pin(input logic v);
        #3 o_event = v;
    endtask
endmodule // mfs_ext_model

// *** sim/mfs_seq_bench.sv ***
// Self-checking bench for the method step sequencer
`timescale 1ns/1ps
`include "mfs_regs.svh"

module mfs_seq_bench;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_touch = 1'b0;
    logic [31:0] o_rdata;
    logic i_event;
    logic i_pump_done;
    logic o_pump_run;
    logic o_pump_dir;
    logic o_valve;
    logic o_running;
    logic [2:0] o_trig;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int pcnt = 0;
    localparam logic [15:0] E = 16'h0000;
    localparam logic [15:0] EV = {mfs_pkg::MFS_OP_EVENT, 12'h002};

    mfs_seq mfs_seq_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_event(i_event), .i_touch(i_touch),
        .i_pump_done(i_pump_done), .o_pump_run(o_pump_run), .o_pump_dir(o_pump_dir),
        .o_trig(o_trig), .o_valve(o_valve), .o_running(o_running));
    mfs_ext_model ext_i (.i_clk(i_clk), .i_pump_run(o_pump_run), .o_event(i_event),
        .o_pump_done(i_pump_done));

    // 125 MHz clock
    always #4 i_clk = ~i_clk;

    // Cycle ceiling and pump completion count
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (i_pump_done === 1'b1) pcnt <= pcnt + 1;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end

    // ====
    // Bus and step helpers
    function automatic logic [15:0] st(input logic [3:0] o, input logic [11:0] a);
        return {o, a};
    endfunction
    function automatic logic [15:0] tg(input logic [1:0] s, input logic l);
        return st(mfs_pkg::MFS_OP_TRIG, {6'h0, s, 3'h0, l});
    endfunction
    function automatic logic [15:0] vl(input logic [1:0] m);
        return st(mfs_pkg::MFS_OP_VALVE, {10'h0, m});
    endfunction
    function automatic logic [15:0] pm(input logic d);
        return st(mfs_pkg::MFS_OP_PUMP, {11'h0, d});
    endfunction

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // Pointer auto-increments, so one pointer write per block
    task automatic prog(input logic [5:0] b, input logic [15:0] w[$]);
        wr(`MFS_REG_PADDR, {26'h0, b});
        foreach (w[i]) wr(`MFS_REG_PDATA, {16'h0, w[i]});
    endtask
    task automatic mtab(input logic [2:0] m, input logic [5:0] s);
        wr(`MFS_REG_MTAB, {13'h0, m, 10'h0, s});
    endtask
    task automatic go(input logic [2:0] m);
        wr(`MFS_REG_CTRL, {25'h0, m, 4'h1});
    endtask
    task automatic fin(input int n);
        repeat (3) @(posedge i_clk);
        for (int i = 0; i < n && o_running !== 1'b0; i++) @(posedge i_clk);
        chk("o_running", 32'h0, {31'h0, o_running});
    endtask
    task automatic wait_ev();
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 40 && s[1] !== 1'b1; i++) rd(`MFS_REG_STATUS, s);
        chk("waiting", 32'h1, {31'h0, s[1]});
    endtask
    task automatic touch();
        @(posedge i_clk);
        i_touch <= 1'b1;
        @(posedge i_clk);
        i_touch <= 1'b0;
    endtask

    // ====
    // Scenarios
    task automatic t_trig();
        prog(6'd0, '{tg(2'd0, 1'b1), tg(2'd2, 1'b1), tg(2'd1, 1'b1), tg(2'd0, 1'b0), E});
        mtab(3'd0, 6'd0);
        go(3'd0);
        fin(40);
        repeat (20) @(posedge i_clk);
        chk("o_trig", 32'h6, {29'h0, o_trig});
    endtask
    task automatic t_flow();
        int p0;
        p0 = pcnt;
        prog(6'd8, '{pm(1'b0), st(mfs_pkg::MFS_OP_REPEAT, 12'h008), E});
        mtab(3'd1, 6'd8);
        go(3'd1);
        fin(400);
        chk("pumps", 32'h9, 32'(pcnt - p0));
        prog(6'd16, '{tg(2'd2, 1'b0), st(mfs_pkg::MFS_OP_CALL, 12'h003), tg(2'd0, 1'b1), E});
        prog(6'd20, '{tg(2'd1, 1'b0), tg(2'd2, 1'b1), E});
        mtab(3'd2, 6'd16);
        mtab(3'd3, 6'd20);
        go(3'd2);
        fin(60);
        chk("o_trig", 32'h5, {29'h0, o_trig});
        prog(6'd24, '{st(mfs_pkg::MFS_OP_LINK, 12'h005), tg(2'd1, 1'b1), E});
        prog(6'd28, '{tg(2'd0, 1'b0), E});
        mtab(3'd4, 6'd24);
        mtab(3'd5, 6'd28);
        go(3'd4);
        fin(60);
        chk("o_trig", 32'h4, {29'h0, o_trig});
        p0 = pcnt;
        prog(6'd32, '{pm(1'b1), st(mfs_pkg::MFS_OP_STOP, 12'h000), tg(2'd2, 1'b0), E});
        mtab(3'd6, 6'd32);
        go(3'd6);
        fin(60);
        chk("o_trig", 32'h4, {29'h0, o_trig});
        chk("pump", 32'h1, {31'h0, o_pump_run} + 32'(pcnt - p0));
    endtask
    task automatic t_valve();
        logic [31:0] s;
        logic v0;
        prog(6'd40, '{vl(2'h1), EV, vl(2'h2), EV, vl(2'h0), pm(1'b0), EV, pm(1'b1), EV,
            pm(1'b1), EV, vl(2'h1), E});
        mtab(3'd7, 6'd40);
        go(3'd7);
        wait_ev();
        chk("o_valve", 32'h1, {31'h0, o_valve});
        touch();
        wait_ev();
        chk("o_valve", 32'h0, {31'h0, o_valve});
        touch();
        wait_ev();
        v0 = o_valve;
        touch();
        wait_ev();
        chk("o_valve", {31'h0, !v0}, {31'h0, o_valve});
        chk("o_pump_dir", 32'h1, {31'h0, o_pump_dir});
        touch();
        wait_ev();
        chk("o_valve", {31'h0, !v0}, {31'h0, o_valve});
        touch();
        fin(60);
        rd(`MFS_REG_STATUS, s);
        chk("valve mode", 32'h0, {30'h0, s[17:16]});
    endtask
    // Abort while waiting must leave run and drop the manual valve mode
    task automatic t_abort();
        logic [31:0] s;
        prog(6'd60, '{vl(2'h1), EV, E});
        mtab(3'd1, 6'd60);
        go(3'd1);
        wait_ev();
        chk("o_valve", 32'h1, {31'h0, o_valve});
        wr(`MFS_REG_CTRL, 32'h0000_0002);
        fin(4);
        rd(`MFS_REG_STATUS, s);
        chk("valve mode", 32'h0, {30'h0, s[17:16]});
    endtask
    // Wrong stimulus first, then the one wake condition
    task automatic t_evt(input mfs_pkg::mfs_ev_t m, input logic lv);
        ext_i.set_pin(!lv);
        prog(6'd56, '{st(mfs_pkg::MFS_OP_EVENT, {10'h0, m}), E});
        mtab(3'd0, 6'd56);
        go(3'd0);
        repeat (6) @(posedge i_clk);
        ext_i.set_pin(lv);
        if (m != mfs_pkg::MFS_EV_PRESS) touch();
        repeat (8) @(posedge i_clk);
        chk("o_running", 32'h1, {31'h0, o_running});
        if (m == mfs_pkg::MFS_EV_PRESS) begin
            touch();
        end else begin
            ext_i.set_pin(!lv);
        end
        fin(12);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_trig();
        t_flow();
        t_valve();
        t_abort();
        t_evt(mfs_pkg::MFS_EV_RISE, 1'b0);
        t_evt(mfs_pkg::MFS_EV_FALL, 1'b1);
        t_evt(mfs_pkg::MFS_EV_PRESS, 1'b1);
        results();
    end
endmodule // mfs_seq_bench
